/* odl_decode.sv */
/*
  Opcode decoder for map rows with low digit 5 to F, including the
  stack-pointer prefixed page. Takes one byte per valid strobe from the
  fetch unit on sys_clk_i and returns a registered decode one cycle on.
  Assumes fetch only presents bytes that start or continue an opcode.

*/
`timescale 1ns/1ps
`default_nettype none
`include "odl_cfg.svh"

module odl_decode (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] opcode_i,
  input wire logic opcode_valid_i,
  input wire logic flush_i,
  output var odl_pkg::odl_dec_t dec_o,
  output logic prefix_pending_o
);

  logic [3:0] op_hi;
  logic [3:0] op_lo;
  odl_pkg::odl_op_t aop;
  odl_pkg::odl_dec_t base_d;
  odl_pkg::odl_dec_t page_d;
  odl_pkg::odl_dec_t sel_d;
  odl_pkg::odl_dec_t dec_d;
  odl_pkg::odl_dec_t dec_q;
  logic prefix_d;
  logic prefix_q;

  assign op_hi = opcode_i[7:4];
  assign op_lo = opcode_i[3:0];
  assign aop = odl_pkg::alu_op(op_lo);

  odl_sp_page u_sp_page (
    .opcode_i(opcode_i),
    .dec_o(page_d)
  );

  // Unprefixed page
  always_comb
  begin
    base_d = odl_pkg::ent(odl_pkg::O_NONE, odl_pkg::M_INH, `ODL_CYC_NONE);
    case (op_hi)
      4'h0:
        base_d = odl_pkg::ent(op_lo[0] ? odl_pkg::O_BR_BIT_CLR
                              : odl_pkg::O_BR_BIT_SET,
                              odl_pkg::M_DIR, 4'h5);
      4'h1:
        base_d = odl_pkg::ent(op_lo[0] ? odl_pkg::O_CLR_BIT
                              : odl_pkg::O_SET_BIT,
                              odl_pkg::M_DIR, 4'h4);
      4'h2:
      begin
        case (op_lo)
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_BR_HC_CLR,
                                      odl_pkg::M_REL, 4'h3);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_BR_HC_SET,
                                      odl_pkg::M_REL, 4'h3);
          4'hA: base_d = odl_pkg::ent(odl_pkg::O_BR_PLUS,
                                      odl_pkg::M_REL, 4'h3);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_BR_IRQ_HIGH,
                                      odl_pkg::M_REL, 4'h3);
          default: ;
        endcase
      end
      4'h3:
      begin
        case (op_lo)
          4'h6: base_d = odl_pkg::ent(odl_pkg::O_ROR,
                                      odl_pkg::M_DIR, 4'h4);
          4'h7: base_d = odl_pkg::ent(odl_pkg::O_ASR,
                                      odl_pkg::M_DIR, 4'h4);
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_LSL,
                                      odl_pkg::M_DIR, 4'h4);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_ROL,
                                      odl_pkg::M_DIR, 4'h4);
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_INC,
                                      odl_pkg::M_DIR, 4'h4);
          4'hB: base_d = odl_pkg::ent(odl_pkg::O_DEC_BNZ,
                                      odl_pkg::M_DIR, 4'h5);
          4'hD: base_d = odl_pkg::ent(odl_pkg::O_TEST,
                                      odl_pkg::M_DIR, 4'h3);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_CLR,
                                      odl_pkg::M_DIR, 4'h3);
          default: ;
        endcase
      end
      4'h4:
      begin
        case (op_lo)
          4'h5: base_d = odl_pkg::ent(odl_pkg::O_LD_PAIR,
                                      odl_pkg::M_IMM, 4'h3);
          4'h6: base_d = odl_pkg::ent(odl_pkg::O_ROR,
                                      odl_pkg::M_INH, 4'h1);
          4'h7: base_d = odl_pkg::ent(odl_pkg::O_ASR,
                                      odl_pkg::M_INH, 4'h1);
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_LSL,
                                      odl_pkg::M_INH, 4'h1);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_ROL,
                                      odl_pkg::M_INH, 4'h1);
          4'hA: base_d = odl_pkg::ent(odl_pkg::O_DEC,
                                      odl_pkg::M_INH, 4'h1);
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_INC,
                                      odl_pkg::M_INH, 4'h1);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_CLR,
                                      odl_pkg::M_INH, 4'h1);
          4'hB: base_d = odl_pkg::ent(odl_pkg::O_DEC_BNZ,
                                      odl_pkg::M_INH, 4'h3);
          4'hE: base_d = odl_pkg::ent(odl_pkg::O_MOVE,
                                      odl_pkg::M_D2D, 4'h5);
          default: ;
        endcase
      end
      4'h5:
      begin
        case (op_lo)
          4'h5: base_d = odl_pkg::ent(odl_pkg::O_LD_PAIR,
                                      odl_pkg::M_DIR, 4'h4);
          4'h7: base_d = odl_pkg::ent(odl_pkg::O_ASR,
                                      odl_pkg::M_INH, 4'h1);
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_LSL,
                                      odl_pkg::M_INH, 4'h1);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_ROL,
                                      odl_pkg::M_INH, 4'h1);
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_INC,
                                      odl_pkg::M_INH, 4'h1);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_CLR,
                                      odl_pkg::M_INH, 4'h1);
          default: ;
        endcase
      end
      4'h6:
      begin
        case (op_lo)
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_LSL,
                                      odl_pkg::M_IDX8, 4'h4);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_ROL,
                                      odl_pkg::M_IDX8, 4'h4);
          4'hE: base_d = odl_pkg::ent(odl_pkg::O_MOVE,
                                      odl_pkg::M_IMM2D, 4'h4);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_CLR,
                                      odl_pkg::M_IDX8, 4'h3);
          default: ;
        endcase
      end
      4'h7:
      begin
        case (op_lo)
          4'h5: base_d = odl_pkg::ent(odl_pkg::O_CMP_PAIR,
                                      odl_pkg::M_DIR, 4'h4);
          4'hE: base_d = odl_pkg::ent(odl_pkg::O_MOVE,
                                      odl_pkg::M_IXPD, 4'h4);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_CLR,
                                      odl_pkg::M_IX, `ODL_CYC_CLR_IX);
          default: ;
        endcase
      end
      4'h8:
      begin
        case (op_lo)
          4'h5: base_d = odl_pkg::ent(odl_pkg::O_FLAGS_TO_ACC,
                                      odl_pkg::M_INH, 4'h1);
          4'h6: base_d = odl_pkg::ent(odl_pkg::O_PULL_ACC,
                                      odl_pkg::M_INH, 4'h2);
          4'h7: base_d = odl_pkg::ent(odl_pkg::O_PUSH_ACC,
                                      odl_pkg::M_INH, 4'h2);
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_PULL_IDXL,
                                      odl_pkg::M_INH, 4'h2);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_PUSH_IDXL,
                                      odl_pkg::M_INH, 4'h2);
          4'hA: base_d = odl_pkg::ent(odl_pkg::O_PULL_IDXH,
                                      odl_pkg::M_INH, 4'h2);
          4'hB: base_d = odl_pkg::ent(odl_pkg::O_PUSH_IDXH,
                                      odl_pkg::M_INH, 4'h2);
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_CLR_IDXH,
                                      odl_pkg::M_INH, 4'h1);
          4'hE: base_d = odl_pkg::ent(odl_pkg::O_STOP,
                                      odl_pkg::M_INH, 4'h1);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_WAIT,
                                      odl_pkg::M_INH, 4'h1);
          default: ;
        endcase
      end
      4'h9:
      begin
        case (op_lo)
          4'h5: base_d = odl_pkg::ent(odl_pkg::O_SP_TO_IDX,
                                      odl_pkg::M_INH, 4'h2);
          4'h7: base_d = odl_pkg::ent(odl_pkg::O_ACC_TO_IDX,
                                      odl_pkg::M_INH, 4'h1);
          4'h8: base_d = odl_pkg::ent(odl_pkg::O_CLR_CARRY,
                                      odl_pkg::M_INH, 4'h1);
          4'h9: base_d = odl_pkg::ent(odl_pkg::O_SET_CARRY,
                                      odl_pkg::M_INH, 4'h1);
          4'hA: base_d = odl_pkg::ent(odl_pkg::O_CLR_IMASK,
                                      odl_pkg::M_INH, 4'h2);
          4'hB: base_d = odl_pkg::ent(odl_pkg::O_SET_IMASK,
                                      odl_pkg::M_INH, 4'h2);
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_RESET_SP,
                                      odl_pkg::M_INH, 4'h1);
          4'hD: base_d = odl_pkg::ent(odl_pkg::O_NOP,
                                      odl_pkg::M_INH, 4'h1);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_IDX_TO_ACC,
                                      odl_pkg::M_INH, 4'h1);
          default: ;
        endcase
      end
      4'hA:
      begin
        case (op_lo)
          4'h6, 4'hB, 4'hE:
            base_d = odl_pkg::ent(aop, odl_pkg::M_IMM,
                                  `ODL_CYC_IMM);
          4'hF:
            base_d = odl_pkg::ent(odl_pkg::O_ADD_IMM_IDX,
                                  odl_pkg::M_IMM, `ODL_CYC_AIX);
          default: ;
        endcase
      end
      4'hB:
      begin
        case (op_lo)
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_JUMP,
                                      odl_pkg::M_DIR, 4'h2);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_ST_IDX,
                                      odl_pkg::M_DIR, 4'h3);
          default: ;
        endcase
      end
      4'hC:
      begin
        case (op_lo)
          4'h8, 4'h9, 4'hA, 4'hF:
            base_d = odl_pkg::ent(aop, odl_pkg::M_EXT,
                                  `ODL_CYC_EXT);
          default: ;
        endcase
      end
      4'hD:
      begin
        case (op_lo)
          4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF:
            base_d = odl_pkg::ent(aop, odl_pkg::M_IDX16,
                                  `ODL_CYC_IDX16);
          default: ;
        endcase
      end
      4'hE:
      begin
        case (op_lo)
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_JUMP,
                                      odl_pkg::M_IDX8, 4'h3);
          4'hD: base_d = odl_pkg::ent(odl_pkg::O_CALL,
                                      odl_pkg::M_IDX8, 4'h5);
          4'hF: base_d = odl_pkg::ent(odl_pkg::O_ST_IDX,
                                      odl_pkg::M_IDX8, 4'h3);
          default: ;
        endcase
      end
      4'hF:
      begin
        case (op_lo)
          4'hC: base_d = odl_pkg::ent(odl_pkg::O_JUMP,
                                      odl_pkg::M_IX, 4'h2);
          4'hD: base_d = odl_pkg::ent(odl_pkg::O_CALL,
                                      odl_pkg::M_IX, 4'h4);
          default:
            base_d = odl_pkg::ent(aop, odl_pkg::M_IX,
                                  `ODL_CYC_IX);
        endcase
      end
      default: ;
    endcase
    // Bit number rides in the low digit's upper three bits
    if (op_hi <= 4'h1)
    begin
      base_d.bit_idx = op_lo[3:1];
    end
    // Inherent entries in columns 4 and 5 act on a register
    if (base_d.mode == odl_pkg::M_INH && op_hi == 4'h4)
    begin
      base_d.tgt = odl_pkg::T_ACC;
    end
    if (base_d.mode == odl_pkg::M_INH && op_hi == 4'h5)
    begin
      base_d.tgt = odl_pkg::T_IDX;
    end
  end

  // Page select and rows outside this map slice
  always_comb
  begin
    sel_d = prefix_q ? page_d : base_d;
    if (op_lo < `ODL_LOW_FIRST)
    begin
      // Not decoded here; another decoder owns rows 0 to 4
      sel_d.in_map = 1'b0;
      sel_d.illegal = 1'b0;
      sel_d.op = odl_pkg::O_OTHER;
      sel_d.len = `ODL_LEN_NONE;
      sel_d.cyc = `ODL_CYC_NONE;
    end
  end

  always_comb
  begin
    prefix_d = prefix_q;
    dec_d = dec_q;
    dec_d.valid = 1'b0;
    if (flush_i)
    begin
      prefix_d = 1'b0;
    end
    else if (opcode_valid_i)
    begin
      // A second prefix byte decodes as a blank page entry
      if (!prefix_q && opcode_i == `ODL_PREFIX_SP)
      begin
        prefix_d = 1'b1;
      end
      else
      begin
        prefix_d = 1'b0;
        dec_d = sel_d;
        dec_d.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      prefix_q <= 1'b0;
      dec_q <= '0;
    end
    else
    begin
      prefix_q <= prefix_d;
      dec_q <= dec_d;
    end
  end

  assign dec_o = dec_q;
  assign prefix_pending_o = prefix_q;

endmodule

`default_nettype wire

/* odl_cfg.svh */
/*
  Constants for the low-rows opcode decoder: prefix byte, map bounds,
  base instruction lengths per addressing mode and shared cycle counts.
  Assumes inclusion by the decoder package and modules only.
*/
`ifndef ODL_CFG_SVH
`define ODL_CFG_SVH

// Stack-pointer page prefix and its page columns
`define ODL_PREFIX_SP 8'h9E
`define ODL_SP_HI_8R 4'h6
`define ODL_SP_HI_16 4'hD
`define ODL_SP_HI_8A 4'hE

// First low digit held by this decoder
`define ODL_LOW_FIRST 4'h5

// Base lengths in bytes per addressing mode
`define ODL_LEN_NONE 3'h0
`define ODL_LEN_INH 3'h1
`define ODL_LEN_IMM 3'h2
`define ODL_LEN_DIR 3'h2
`define ODL_LEN_EXT 3'h3
`define ODL_LEN_IX 3'h1
`define ODL_LEN_IDX8 3'h2
`define ODL_LEN_IDX16 3'h3
`define ODL_LEN_SP8 3'h3
`define ODL_LEN_SP16 3'h4
`define ODL_LEN_REL 3'h2
`define ODL_LEN_D2D 3'h3
`define ODL_LEN_IMM2D 3'h3
`define ODL_LEN_IXPD 3'h2

// Cycle counts shared across the entries of one column
`define ODL_CYC_NONE 4'h0
`define ODL_CYC_IMM 4'h2
`define ODL_CYC_EXT 4'h4
`define ODL_CYC_IDX16 4'h4
`define ODL_CYC_SP16 4'h5
`define ODL_CYC_SP8 4'h4
`define ODL_CYC_IX 4'h2
// Not printed in the map; plain defaults
`define ODL_CYC_CLR_IX 4'h2
`define ODL_CYC_AIX 4'h2

`endif

/* odl_pkg.sv */
/*
  Types and shared decode helpers for the low-rows opcode decoder.
  Assumes odl_cfg.svh is on the include path.
*/
`default_nettype none
`include "odl_cfg.svh"

package odl_pkg;

  typedef enum logic [5:0] {
    O_NONE, O_OTHER, O_BR_BIT_SET, O_BR_BIT_CLR, O_SET_BIT, O_CLR_BIT,
    O_LD_PAIR, O_CMP_PAIR, O_FLAGS_TO_ACC, O_SP_TO_IDX, O_ACC_TO_IDX,
    O_IDX_TO_ACC, O_CLR_CARRY, O_SET_CARRY, O_CLR_IMASK, O_SET_IMASK,
    O_RESET_SP, O_NOP, O_PULL_ACC, O_PUSH_ACC, O_PULL_IDXL, O_PUSH_IDXL,
    O_PULL_IDXH, O_PUSH_IDXH, O_CLR_IDXH, O_STOP, O_WAIT, O_ROR, O_ASR,
    O_LSL, O_ROL, O_DEC, O_INC, O_CLR, O_TEST, O_DEC_BNZ, O_BR_HC_CLR,
    O_BR_HC_SET, O_BR_PLUS, O_BR_IRQ_HIGH, O_BIT_TEST, O_LD_ACC,
    O_ST_ACC, O_XOR, O_ADC, O_OR, O_ADD, O_LD_IDX, O_ST_IDX,
    O_ADD_IMM_IDX, O_JUMP, O_CALL, O_MOVE
  } odl_op_t;

  typedef enum logic [3:0] {
    M_INH, M_IMM, M_DIR, M_EXT, M_IX, M_IDX8, M_IDX16, M_SP8, M_SP16,
    M_REL, M_D2D, M_IMM2D, M_IXPD
  } odl_mode_t;

  typedef enum logic [1:0] {T_MEM, T_ACC, T_IDX} odl_tgt_t;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic in_map;
    logic prefixed;
    odl_op_t op;
    odl_mode_t mode;
    odl_tgt_t tgt;
    logic [2:0] bit_idx;
    logic [2:0] len;
    logic [3:0] cyc;
  } odl_dec_t;

  // Branch offset or 16-bit immediate adds one byte to the mode's base
  function automatic logic [2:0] len_of(odl_mode_t m, odl_op_t o);
    logic [2:0] b;
    logic x;
    case (m)
      M_INH: b = `ODL_LEN_INH;
      M_IMM: b = `ODL_LEN_IMM;
      M_DIR: b = `ODL_LEN_DIR;
      M_EXT: b = `ODL_LEN_EXT;
      M_IX: b = `ODL_LEN_IX;
      M_IDX8: b = `ODL_LEN_IDX8;
      M_IDX16: b = `ODL_LEN_IDX16;
      M_SP8: b = `ODL_LEN_SP8;
      M_SP16: b = `ODL_LEN_SP16;
      M_REL: b = `ODL_LEN_REL;
      M_D2D: b = `ODL_LEN_D2D;
      M_IMM2D: b = `ODL_LEN_IMM2D;
      M_IXPD: b = `ODL_LEN_IXPD;
      default: b = `ODL_LEN_INH;
    endcase
    x = (o == O_BR_BIT_SET) || (o == O_BR_BIT_CLR) || (o == O_DEC_BNZ)
      || ((o == O_LD_PAIR) && (m == M_IMM));
    return b + {2'h0, x};
  endfunction

  // Arithmetic and load/store columns share one low-digit table
  function automatic odl_op_t alu_op(logic [3:0] lo);
    case (lo)
      4'h5: return O_BIT_TEST;
      4'h6: return O_LD_ACC;
      4'h7: return O_ST_ACC;
      4'h8: return O_XOR;
      4'h9: return O_ADC;
      4'hA: return O_OR;
      4'hB: return O_ADD;
      4'hE: return O_LD_IDX;
      4'hF: return O_ST_IDX;
      default: return O_NONE;
    endcase
  endfunction

  function automatic odl_dec_t ent(odl_op_t o, odl_mode_t m,
                                   logic [3:0] c);
    odl_dec_t d;
    d = '0;
    d.op = o;
    d.mode = m;
    d.cyc = c;
    d.len = len_of(m, o);
    d.in_map = 1'b1;
    d.illegal = (o == O_NONE);
    d.tgt = T_MEM;
    return d;
  endfunction

endpackage

`default_nettype wire

/* odl_sp_page.sv */
/*
  Combinational decode of the byte that follows the stack-pointer
  prefix. Assumes the caller tracks the prefix and masks rows 0 to 4.
*/
`timescale 1ns/1ps
`default_nettype none
`include "odl_cfg.svh"

module odl_sp_page (
  input wire logic [7:0] opcode_i,
  output var odl_pkg::odl_dec_t dec_o
);

  logic [3:0] hi;
  logic [3:0] lo;
  odl_pkg::odl_op_t aop;

  always_comb
  begin
    hi = opcode_i[7:4];
    lo = opcode_i[3:0];
    aop = odl_pkg::alu_op(lo);
    dec_o = odl_pkg::ent(odl_pkg::O_NONE, odl_pkg::M_INH, `ODL_CYC_NONE);
    case (hi)
      `ODL_SP_HI_8R:
      begin
        case (lo)
          4'h6: dec_o = odl_pkg::ent(odl_pkg::O_ROR, odl_pkg::M_SP8, 4'h5);
          4'h7: dec_o = odl_pkg::ent(odl_pkg::O_ASR, odl_pkg::M_SP8, 4'h5);
          4'h8: dec_o = odl_pkg::ent(odl_pkg::O_LSL, odl_pkg::M_SP8, 4'h5);
          4'h9: dec_o = odl_pkg::ent(odl_pkg::O_ROL, odl_pkg::M_SP8, 4'h5);
          4'hA: dec_o = odl_pkg::ent(odl_pkg::O_DEC, odl_pkg::M_SP8, 4'h5);
          4'hC: dec_o = odl_pkg::ent(odl_pkg::O_INC, odl_pkg::M_SP8, 4'h5);
          4'hB: dec_o = odl_pkg::ent(odl_pkg::O_DEC_BNZ, odl_pkg::M_SP8,
                                     4'h6);
          4'hD: dec_o = odl_pkg::ent(odl_pkg::O_TEST, odl_pkg::M_SP8,
                                     4'h4);
          4'hF: dec_o = odl_pkg::ent(odl_pkg::O_CLR, odl_pkg::M_SP8, 4'h4);
          default: ;
        endcase
      end
      `ODL_SP_HI_16:
        dec_o = odl_pkg::ent(aop, odl_pkg::M_SP16, `ODL_CYC_SP16);
      `ODL_SP_HI_8A:
        dec_o = odl_pkg::ent(aop, odl_pkg::M_SP8, `ODL_CYC_SP8);
      default: ;
    endcase
    dec_o.prefixed = 1'b1;
  end

endmodule

`default_nettype wire

/* odl_decode_props.sv */
/*
  Checker for the low-rows opcode decoder, bound to odl_decode.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module odl_decode_props (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] opcode_i,
  input wire logic opcode_valid_i,
  input wire logic flush_i,
  input wire odl_pkg::odl_dec_t dec_o,
  input wire logic prefix_pending_o
);
  logic take;
  logic odd;
  logic [2:0] bsel;
  logic [3:0] hi;
  logic [3:0] lo;
  assign take = opcode_valid_i && !flush_i;
  assign odd = opcode_i[0];
  assign bsel = opcode_i[3:1];
  assign hi = opcode_i[7:4];
  assign lo = opcode_i[3:0];
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_decode_latency: assert property (
    take && (prefix_pending_o || opcode_i != 8'h9E) |=> dec_o.valid)
    else $error("decode pulse missing");
  a_prefix_enter: assert property (
    take && !prefix_pending_o && opcode_i == 8'h9E
    |=> prefix_pending_o && !dec_o.valid)
    else $error("prefix not held");
  a_prefix_mark: assert property (
    take && prefix_pending_o |=> dec_o.prefixed && !prefix_pending_o)
    else $error("prefixed decode wrong");
  a_flush_drop: assert property (
    flush_i |=> !dec_o.valid && !prefix_pending_o)
    else $error("flush ignored");
  a_bit_branch: assert property (
    take && !prefix_pending_o && hi == 4'h0 && lo >= 4'h5
    |=> dec_o.len == 3'h3 && dec_o.cyc == 4'h5
    && dec_o.bit_idx == $past(bsel))
    else $error("bit branch decode wrong");
  a_bit_write: assert property (
    take && !prefix_pending_o && hi == 4'h1 && lo >= 4'h5
    |=> dec_o.len == 3'h2 && dec_o.cyc == 4'h4
    && dec_o.op == ($past(odd) ? odl_pkg::O_CLR_BIT : odl_pkg::O_SET_BIT))
    else $error("bit write decode wrong");
  a_rel_branch: assert property (
    take && !prefix_pending_o && hi == 4'h2
    && lo inside {4'h8, 4'h9, 4'hA, 4'hF}
    |=> dec_o.mode == odl_pkg::M_REL && dec_o.len == 3'h2
    && dec_o.cyc == 4'h3)
    else $error("relative branch wrong");
  a_stack_word: assert property (
    take && prefix_pending_o && hi == 4'hD && lo >= 4'h5 && lo <= 4'hB
    |=> dec_o.len == 3'h4 && dec_o.cyc == 4'h5)
    else $error("stack word timing wrong");
  a_outside_map: assert property (
    take && lo < 4'h5 |=> !dec_o.in_map && !dec_o.illegal)
    else $error("foreign row claimed");
  c_prefixed: cover property (dec_o.valid && dec_o.prefixed);
  c_illegal: cover property (dec_o.valid && dec_o.illegal);
  c_flush: cover property (flush_i && opcode_valid_i);
endmodule
bind odl_decode odl_decode_props chk_u (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .opcode_i(opcode_i),
  .opcode_valid_i(opcode_valid_i),
  .flush_i(flush_i),
  .dec_o(dec_o),
  .prefix_pending_o(prefix_pending_o)
);
`default_nettype wire

/* odl_fetch_model.sv */
/*
  Fetch-side partner: presents each opcode byte for one cycle; put leaves the strobe high until idle.
  Assumes its tasks are called just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module odl_fetch_model (
  input wire logic sys_clk_i,
  output logic [7:0] opcode_o,
  output logic valid_o
);
  initial
  begin
    opcode_o = 8'h00;
    valid_o = 1'b0;
  end
  // No stall exists, so bytes may stream every cycle
  task automatic put(input logic [7:0] b);
    opcode_o = b;
    valid_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
  endtask
  // Released bus shows the inverse so a stale byte cannot pass
  task automatic idle();
    valid_o = 1'b0;
    opcode_o = ~opcode_o;
    @(posedge sys_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

/* tb_odl_decode.sv */
/*
  Testbench for odl_decode: table of decodes, then prefix, flush,
  hold, out-of-map and reset cases. Assumes odl_fetch_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_odl_decode;
  typedef struct packed {
    logic [8:0] b;
    odl_pkg::odl_op_t op;
    odl_pkg::odl_mode_t m;
    logic [2:0] len;
    logic [3:0] cyc;
  } odl_row_t;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic flush_i = 1'b0;
  logic [7:0] opcode;
  logic opcode_valid;
  logic pend;
  odl_pkg::odl_dec_t d;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  // Bit 8 of b marks a byte sent after the stack prefix
  odl_row_t rows [$] = '{
    '{9'h005,odl_pkg::O_BR_BIT_CLR,odl_pkg::M_DIR,3'h3,4'h5},
    '{9'h00E,odl_pkg::O_BR_BIT_SET,odl_pkg::M_DIR,3'h3,4'h5},
    '{9'h01C,odl_pkg::O_SET_BIT,odl_pkg::M_DIR,3'h2,4'h4},
    '{9'h045,odl_pkg::O_LD_PAIR,odl_pkg::M_IMM,3'h3,4'h3},
    '{9'h075,odl_pkg::O_CMP_PAIR,odl_pkg::M_DIR,3'h2,4'h4},
    '{9'h085,odl_pkg::O_FLAGS_TO_ACC,odl_pkg::M_INH,3'h1,4'h1},
    '{9'h095,odl_pkg::O_SP_TO_IDX,odl_pkg::M_INH,3'h1,4'h2},
    '{9'h08F,odl_pkg::O_WAIT,odl_pkg::M_INH,3'h1,4'h1},
    '{9'h04B,odl_pkg::O_DEC_BNZ,odl_pkg::M_INH,3'h2,4'h3},
    '{9'h03B,odl_pkg::O_DEC_BNZ,odl_pkg::M_DIR,3'h3,4'h5},
    '{9'h036,odl_pkg::O_ROR,odl_pkg::M_DIR,3'h2,4'h4},
    '{9'h16B,odl_pkg::O_DEC_BNZ,odl_pkg::M_SP8,3'h4,4'h6},
    '{9'h02F,odl_pkg::O_BR_IRQ_HIGH,odl_pkg::M_REL,3'h2,4'h3},
    '{9'h0C8,odl_pkg::O_XOR,odl_pkg::M_EXT,3'h3,4'h4},
    '{9'h1D9,odl_pkg::O_ADC,odl_pkg::M_SP16,3'h4,4'h5},
    '{9'h0FB,odl_pkg::O_ADD,odl_pkg::M_IX,3'h1,4'h2},
    '{9'h0ED,odl_pkg::O_CALL,odl_pkg::M_IDX8,3'h2,4'h5},
    '{9'h0EF,odl_pkg::O_ST_IDX,odl_pkg::M_IDX8,3'h2,4'h3},
    '{9'h0BC,odl_pkg::O_JUMP,odl_pkg::M_DIR,3'h2,4'h2},
    '{9'h07E,odl_pkg::O_MOVE,odl_pkg::M_IXPD,3'h2,4'h4},
    '{9'h04E,odl_pkg::O_MOVE,odl_pkg::M_D2D,3'h3,4'h5},
    '{9'h0AF,odl_pkg::O_ADD_IMM_IDX,odl_pkg::M_IMM,3'h2,4'h2},
    '{9'h03A,odl_pkg::O_NONE,odl_pkg::M_INH,3'h1,4'h0}
  };
  odl_fetch_model fm_u (
    .sys_clk_i(sys_clk_i),
    .opcode_o(opcode),
    .valid_o(opcode_valid)
  );
  odl_decode dut_u (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .opcode_i(opcode),
    .opcode_valid_i(opcode_valid),
    .flush_i(flush_i),
    .dec_o(d),
    .prefix_pending_o(pend)
  );
  always #2.5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %0h want %0h", $time, s, e);
    end
  endtask
  task automatic send(input logic [8:0] pb);
    if (pb[8])
      fm_u.put(8'h9E);
    fm_u.put(pb[7:0]);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the fewer than sixty cycles the run needs
  always @(posedge sys_clk_i)
  begin
    cyc_n++;
    if (cyc_n == 2000)
    begin
      error_cnt++;
      results();
    end
  end
  initial
  begin
    odl_row_t r;
    repeat (16) @(posedge sys_clk_i);
    #1;
    chk(32'({d, pend}), 32'h0);
    reset_n_i = 1'b1;
    fm_u.idle();
    // Back to back, so each row also tests streaming
    foreach (rows[i])
    begin
      r = rows[i];
      send(r.b);
      chk(32'({d.valid, d.op, d.len, d.cyc}), 32'({1'b1, r.op, r.len, r.cyc}));
      chk(32'({d.prefixed, d.illegal, d.in_map}),
          32'({r.b[8], r.op == odl_pkg::O_NONE, 1'b1}));
      if (r.op != odl_pkg::O_NONE)
        chk(32'(d.mode), 32'(r.m));
      chk(32'(d.bit_idx), 32'(r.b[8:5] == 4'h0 ? r.b[3:1] : 3'h0));
    end
    fm_u.put(8'h9E);
    chk(32'({pend, d.valid}), 32'h2);
    flush_i = 1'b1;
    fm_u.put(8'hD6);
    flush_i = 1'b0;
    chk(32'({pend, d.valid}), 32'h0);
    send(9'h0D6);
    chk(32'({d.prefixed, d.mode, d.len, d.cyc}), 32'({1'b0, odl_pkg::M_IDX16, 3'h3, 4'h4}));
    // Inherent DEC and INC name their register through the target field
    send(9'h04A);
    chk(32'(d.tgt), 32'(odl_pkg::T_ACC));
    send(9'h05C);
    chk(32'(d.tgt), 32'(odl_pkg::T_IDX));
    send(9'h19E);
    chk(32'({d.valid, d.prefixed, d.illegal, pend, d.len, d.cyc}), 32'h710);
    send(9'h045);
    fm_u.idle();
    chk(32'({d.valid, d.op, d.len}), 32'({1'b0, odl_pkg::O_LD_PAIR, 3'h3}));
    fm_u.put(8'h03);
    chk(32'({d.valid, d.in_map, d.illegal, d.op, d.len, d.cyc}),
        32'({3'h4, odl_pkg::O_OTHER, 3'h0, 4'h0}));
    fm_u.put(8'h9E);
    reset_n_i = 1'b0;
    fm_u.idle();
    chk(32'({d, pend}), 32'h0);
    reset_n_i = 1'b1;
    fm_u.idle();
    send(9'h16D);
    chk(32'({d.op, d.len, d.cyc}), 32'({odl_pkg::O_TEST, 3'h3, 4'h4}));
    results();
  end
endmodule
`default_nettype wire
